// file: rtl/atc_pkg.sv
package atc_pkg;
	// ==========================================
	// register map
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_START = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h3;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
	localparam logic [3:0] ADDR_SEQLEN = 4'h5;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	// ==========================================
	// control field positions
	localparam int CTRL_PWR = 0;
	localparam int CTRL_ETRIG = 1;
	localparam int CTRL_LEVEL = 2;
	localparam int CTRL_POL = 3;
	localparam int CTRL_WAITH = 4;
	// status / irq field positions
	localparam int ST_BUSY = 0;
	localparam int ST_SAMPLE = 1;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_OVR = 1;
	localparam int IRQ_W = 2;
	// ==========================================
	// timing
	localparam int CLK_MHZ = 100;
	localparam int SAMPLE_NS = 40;
	localparam int SAMPLE_CYC = (SAMPLE_NS * CLK_MHZ + 999) / 1000;
	localparam int CONV_NS = 100;
	localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0] SEQLEN_RST = 4'h4;
	typedef struct packed {
		logic pwr;
		logic etrig;
		logic level;
		logic pol;
		logic waith;
	} atc_ctrl_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} atc_bus_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SAMP = 2'b01,
		ST_CONV = 2'b10
	} atc_state_t;
endpackage

// file: rtl/atc_trig_detect.sv
`timescale 1ns/10ps
`default_nettype none
module atc_trig_detect (
	input wire logic clk,
	input wire logic nrst,
	input wire logic trig_pin,
	input wire logic pol,
	input wire logic level_mode,
	output logic level_act,
	output logic edge_evt
);
	// ==========================================
	// two-flop synchroniser, then edge detect on the second stage
	logic s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;
	logic act;
	always_comb begin
		s1_d = trig_pin;
		s2_d = s1_q;
		s3_d = s2_q;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
		end
	end
	assign act = s2_q ^ ~pol;
	assign level_act = level_mode & act;
	assign edge_evt = ~level_mode & act & ~(s3_q ^ ~pol);
endmodule // atc_trig_detect
`default_nettype wire

// file: rtl/atc_irq.sv
`timescale 1ns/10ps
`default_nettype none
module atc_irq #(
	parameter int W = 2
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [W-1:0] evt,
	input wire logic clr_wr,
	input wire logic mask_wr,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] stat,
	output logic [W-1:0] mask,
	output logic irq
);
	logic [W-1:0] stat_q, stat_d, mask_q, mask_d;
	always_comb begin
		// set wins over a simultaneous write-one clear
		stat_d = (stat_q & ~(clr_wr ? wdata : '0)) | evt;
		mask_d = mask_wr ? wdata : mask_q;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stat_q <= '0;
			mask_q <= '0;
		end else begin
			stat_q <= stat_d;
			mask_q <= mask_d;
		end
	end
	assign stat = stat_q;
	assign mask = mask_q;
	assign irq = |(stat_q & mask_q);
endmodule // atc_irq
`default_nettype wire

// file: rtl/atc_ctrl.sv
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module atc_ctrl
	import atc_pkg::*;
#(
	parameter int SAMP_CYC = SAMPLE_CYC,
	parameter int CNV_CYC = CONV_CYC
) (
	input wire logic CLK_SYS,
	input wire logic NRST,
	input wire atc_pkg::atc_bus_t BUS,
	output logic [atc_pkg::DATA_W-1:0] RDATA,
	input wire logic EXT_TRIG,
	input wire logic CPU_WAIT,
	output logic SAMPLER_CLK_EN,
	output logic CONV_CLK_EN,
	output logic ANALOG_PWR_EN,
	output logic CONV_STEP,
	output logic SEQ_DONE,
	output logic IRQ
);
	import atc_pkg::*;

	// ==========================================
	// parameter check
	// the one step counter shared by both phases is eight bits wide
	if (SAMP_CYC < 1 || CNV_CYC < 1 || SAMP_CYC > 255 || CNV_CYC > 255) begin : g_bad_cyc
		$error("cycle counts out of range");
	end

	// ==========================================
	// register bus
	function automatic logic hit(input atc_bus_t b, input logic [ADDR_W-1:0] a);
		return b.wr && b.addr == a;
	endfunction
	atc_ctrl_t ctrl_q, ctrl_d;
	logic [3:0] seqlen_q, seqlen_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic [IRQ_W-1:0] irq_stat, irq_mask, irq_evt;
	logic busy, sampling;
	logic wait_s1_q, wait_s1_d, wait_s2_q, wait_s2_d;
	always_comb begin
		ctrl_d = ctrl_q;
		seqlen_d = seqlen_q;
		// processor wait comes from another domain, hence two flops
		wait_s1_d = CPU_WAIT;
		wait_s2_d = wait_s1_q;
		if (hit(BUS, ADDR_CTRL)) begin
			ctrl_d.pwr = BUS.wdata[CTRL_PWR];
			ctrl_d.etrig = BUS.wdata[CTRL_ETRIG];
			ctrl_d.level = BUS.wdata[CTRL_LEVEL];
			ctrl_d.pol = BUS.wdata[CTRL_POL];
			ctrl_d.waith = BUS.wdata[CTRL_WAITH];
		end
		if (hit(BUS, ADDR_SEQLEN)) begin
			seqlen_d = BUS.wdata[3:0];
		end
		rdata_d = '0;
		if (BUS.rd) begin
			case (BUS.addr)
				ADDR_CTRL: begin
					rdata_d[CTRL_PWR] = ctrl_q.pwr;
					rdata_d[CTRL_ETRIG] = ctrl_q.etrig;
					rdata_d[CTRL_LEVEL] = ctrl_q.level;
					rdata_d[CTRL_POL] = ctrl_q.pol;
					rdata_d[CTRL_WAITH] = ctrl_q.waith;
				end
				ADDR_STATUS: begin
					rdata_d[ST_BUSY] = busy;
					rdata_d[ST_SAMPLE] = sampling;
				end
				ADDR_IRQ_STAT: rdata_d[IRQ_W-1:0] = irq_stat;
				ADDR_IRQ_MASK: rdata_d[IRQ_W-1:0] = irq_mask;
				ADDR_SEQLEN: rdata_d[3:0] = seqlen_q;
				default: rdata_d = '0;
			endcase
		end
	end
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			ctrl_q <= '0;
			seqlen_q <= SEQLEN_RST;
			rdata_q <= '0;
			wait_s1_q <= 1'b0;
			wait_s2_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			seqlen_q <= seqlen_d;
			rdata_q <= rdata_d;
			wait_s1_q <= wait_s1_d;
			wait_s2_q <= wait_s2_d;
		end
	end
	assign RDATA = rdata_q;

	// ==========================================
	// trigger
	logic trig_level, trig_edge;
	atc_trig_detect u_trig (
		.clk(CLK_SYS),
		.nrst(NRST),
		.trig_pin(EXT_TRIG),
		.pol(ctrl_q.pol),
		.level_mode(ctrl_q.level),
		.level_act(trig_level),
		.edge_evt(trig_edge)
	);

	// ==========================================
	// sequencer
	atc_state_t st_q, st_d;
	logic [7:0] cnt_q, cnt_d;
	logic [3:0] conv_q, conv_d;
	logic sw_start, ext_start, start, halted, last_done, done_d, done_q, ovr;
	always_comb begin
		sw_start = hit(BUS, ADDR_START) && !ctrl_q.etrig;
		ext_start = ctrl_q.etrig && (trig_level || trig_edge);
		start = ctrl_q.pwr && (sw_start || ext_start);
		halted = wait_s2_q && ctrl_q.waith;
		// a shorter length written mid-sequence lets the count wrap before it matches
		last_done = st_q == ST_CONV && cnt_q == 8'(CNV_CYC - 1) && conv_q == seqlen_q;
		// only a fresh edge during a sequence overruns; level re-assertion does not
		ovr = busy && ctrl_q.etrig && trig_edge;
		st_d = st_q;
		cnt_d = cnt_q;
		conv_d = conv_q;
		done_d = 1'b0;
		case (st_q)
			ST_IDLE: begin
				if (start && !halted) begin
					st_d = ST_SAMP;
					cnt_d = '0;
					conv_d = '0;
				end
			end
			ST_SAMP: begin
				if (!halted) begin
					if (cnt_q == 8'(SAMP_CYC - 1)) begin
						st_d = ST_CONV;
						cnt_d = '0;
					end else begin
						cnt_d = cnt_q + 8'h01;
					end
				end
			end
			ST_CONV: begin
				if (!halted) begin
					if (cnt_q == 8'(CNV_CYC - 1)) begin
						cnt_d = '0;
						if (conv_q == seqlen_q) begin
							done_d = 1'b1;
							// retrigger at once while level still active
							if (ctrl_q.etrig && trig_level) begin
								st_d = ST_SAMP;
								conv_d = '0;
							end else begin
								st_d = ST_IDLE;
							end
						end else begin
							st_d = ST_SAMP;
							conv_d = conv_q + 4'h1;
						end
					end else begin
						cnt_d = cnt_q + 8'h01;
					end
				end
			end
			default: st_d = ST_IDLE;
		endcase
		if (!ctrl_q.pwr) begin
			st_d = ST_IDLE;
			cnt_d = '0;
			conv_d = '0;
			done_d = 1'b0;
		end
	end
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			st_q <= ST_IDLE;
			cnt_q <= '0;
			conv_q <= '0;
			done_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			conv_q <= conv_d;
			done_q <= done_d;
		end
	end
	assign busy = st_q != ST_IDLE;
	assign sampling = st_q == ST_SAMP;
	// sampler clocks stop outside sampling to save dynamic power
	assign SAMPLER_CLK_EN = sampling && !halted && ctrl_q.pwr;
	// quiescent analog draw only goes away with the power-up bit
	assign CONV_CLK_EN = ctrl_q.pwr && busy && !halted;
	assign ANALOG_PWR_EN = ctrl_q.pwr;
	assign CONV_STEP = st_q == ST_CONV && !halted && ctrl_q.pwr;
	assign SEQ_DONE = done_q;

	// ==========================================
	// interrupts
	// done taken from the next-state term so the flag rises with the pulse
	assign irq_evt = {ovr, done_d};
	atc_irq #(.W(IRQ_W)) u_irq (
		.clk(CLK_SYS),
		.nrst(NRST),
		.evt(irq_evt),
		.clr_wr(hit(BUS, ADDR_IRQ_STAT)),
		.mask_wr(hit(BUS, ADDR_IRQ_MASK)),
		.wdata(BUS.wdata[IRQ_W-1:0]),
		.stat(irq_stat),
		.mask(irq_mask),
		.irq(IRQ)
	);

	// ==========================================
	// checks
	a_sw_start_block: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(st_q == ST_IDLE && ctrl_q.etrig && !trig_level && !trig_edge) |=> st_q == ST_IDLE)
		else $error("software start taken with trigger enabled");
	a_trig_latency: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(st_q == ST_IDLE && ctrl_q.pwr && ctrl_q.etrig && trig_edge && !halted && !hit(BUS, ADDR_CTRL))
		|=> st_q == ST_SAMP)
		else $error("trigger did not start sequence in one cycle");
	a_level_noovr: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(busy && ctrl_q.level && !$past(irq_stat[IRQ_OVR]) && !irq_stat[IRQ_OVR]) |=> !irq_stat[IRQ_OVR])
		else $error("overrun set in level mode");
	a_level_retrig: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(last_done && !halted && ctrl_q.pwr && ctrl_q.etrig && trig_level) |=> st_q == ST_SAMP)
		else $error("level trigger did not restart");
	a_sampler_gate: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(st_q != ST_SAMP) |-> !SAMPLER_CLK_EN)
		else $error("sampler clock on while not sampling");
	a_power_off: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		!ctrl_q.pwr |-> (!CONV_CLK_EN && !ANALOG_PWR_EN && !SAMPLER_CLK_EN))
		else $error("converter active while powered down");
	a_abort_seq: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(busy && hit(BUS, ADDR_CTRL) && !BUS.wdata[CTRL_PWR]) |=> (!CONV_CLK_EN && !CONV_STEP) ##1 st_q == ST_IDLE)
		else $error("sequence not aborted by power down");
	a_wait_hold: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(halted && busy && ctrl_q.pwr && !hit(BUS, ADDR_CTRL)) |=> $stable(cnt_q) && $stable(st_q))
		else $error("sequence moved during wait halt");
	a_reset_pwr: assert property (@(posedge CLK_SYS)
		$rose(NRST) |-> !ANALOG_PWR_EN)
		else $error("converter powered after reset");

	// ==========================================
	// checks: starts, overrun, mode and polarity, clock and power gating, wait and reset
	a_level_start: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(st_q == ST_IDLE && ctrl_q.pwr && ctrl_q.etrig && trig_level && !halted && !hit(BUS, ADDR_CTRL))
		|=> st_q == ST_SAMP)
		else $error("level trigger did not start sequence in one cycle");
	a_edge_ovr: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(busy && ctrl_q.etrig && trig_edge) |=> irq_stat[IRQ_OVR])
		else $error("edge during sequence did not flag overrun");
	a_sw_start_run: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(st_q == ST_IDLE && ctrl_q.pwr && !ctrl_q.etrig && !halted && hit(BUS, ADDR_START))
		|=> st_q == ST_SAMP)
		else $error("software start ignored with trigger disabled");
	a_pol_select: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		hit(BUS, ADDR_CTRL) |=> (ctrl_q.level == $past(BUS.wdata[CTRL_LEVEL])
		&& ctrl_q.pol == $past(BUS.wdata[CTRL_POL])))
		else $error("trigger mode or polarity not taken from control write");
	a_sampler_on: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(st_q == ST_SAMP && ctrl_q.pwr && !halted) |-> SAMPLER_CLK_EN)
		else $error("sampler clock off while sampling");
	a_clk_busy: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		!busy |-> (!SAMPLER_CLK_EN && !CONV_CLK_EN))
		else $error("converter clocks on while idle");
	a_analog_on: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		ctrl_q.pwr |-> ANALOG_PWR_EN)
		else $error("analog power dropped while powered up");
	a_step_conv: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		CONV_STEP |-> (CONV_CLK_EN && ANALOG_PWR_EN))
		else $error("conversion step without converter clock");
	a_conv_power: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		CONV_CLK_EN |-> ANALOG_PWR_EN)
		else $error("converter clock on without analog power");
	a_halt_gate: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		halted |-> (!SAMPLER_CLK_EN && !CONV_CLK_EN && !CONV_STEP))
		else $error("converter clocks on during wait halt");
	a_wait_run: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(wait_s2_q && !ctrl_q.waith && busy && ctrl_q.pwr) |=> !($stable(cnt_q) && $stable(st_q)))
		else $error("sequence stalled in wait without halt select");
	a_no_start_off: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		!ctrl_q.pwr |=> st_q == ST_IDLE)
		else $error("sequencer ran while powered down");
	a_reset_idle: assert property (@(posedge CLK_SYS)
		$rose(NRST) |-> (st_q == ST_IDLE && !CONV_CLK_EN && !SAMPLER_CLK_EN))
		else $error("converter not idle after reset");
endmodule // atc_ctrl
`default_nettype wire

// file: testbench/atc_trig_src.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// external trigger source
module atc_trig_src (
	input wire logic clk,
	input wire logic hold,
	input wire logic pulse,
	input wire logic pol,
	output logic pin
);
	logic [3:0] cnt_q = 4'h0;
	always_ff @(posedge clk) begin
		if (pulse) begin
			cnt_q <= 4'h3;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end
	end
	// pulse held 3 cycles so the synchroniser cannot miss it
	assign pin = ~((hold | (cnt_q != 4'h0)) ^ pol);
endmodule // atc_trig_src
`default_nettype wire

// file: testbench/test_adc_trigger_power_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_adc_trigger_power_control;
	import atc_pkg::*;
	logic clk = 0, nrst = 0, wt = 0, hold = 0, pulse = 0, pol = 1, rd_seen = 0;
	atc_bus_t bus = '0;
	logic [15:0] rdata;
	logic trig, sclk, cclk, apwr, step, done, irq;
	int err_total = 0, checks_done = 0, n;
	logic [31:0] seed = 32'd62, t;
	logic [31:0] q_exp[$];
	initial forever #5 clk = ~clk;
	atc_ctrl #(.SAMP_CYC(4), .CNV_CYC(10)) dut (.CLK_SYS(clk), .NRST(nrst), .BUS(bus), .RDATA(rdata),
		.EXT_TRIG(trig), .CPU_WAIT(wt), .SAMPLER_CLK_EN(sclk), .CONV_CLK_EN(cclk), .ANALOG_PWR_EN(apwr),
		.CONV_STEP(step), .SEQ_DONE(done), .IRQ(irq));
	atc_trig_src src (.clk(clk), .hold(hold), .pulse(pulse), .pol(pol), .pin(trig));
	// ==========================================
	// helpers
	function automatic logic [15:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[15:0];
	endfunction
	function automatic logic [15:0] cw(input logic p, e, l, po, w);
		cw = '0;
		cw[CTRL_PWR] = p;
		cw[CTRL_ETRIG] = e;
		cw[CTRL_LEVEL] = l;
		cw[CTRL_POL] = po;
		cw[CTRL_WAITH] = w;
	endfunction
	function automatic logic sig(input int s);
		case (s)
			0: sig = cclk;
			1: sig = done;
			default: sig = sclk;
		endcase
	endfunction
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		bus <= {1'b1, 1'b0, a, d};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
		@(posedge clk);
		bus <= {1'b0, 1'b1, a, 16'h0000};
		q_exp.push_back({m, e});
		@(posedge clk);
		bus.rd <= 1'b0;
	endtask
	task tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// bounded wait on a design output, counts edges taken
	task wait_on(input int s, input int lim, output int c);
		c = 0;
		do begin
			tick(1);
			c++;
		end while (sig(s) !== 1'b1 && c < lim);
		if (sig(s) !== 1'b1) begin
			err_total++;
			$display("MISMATCH t=%0t wait ran out", $time);
			report_and_stop;
		end
	endtask
	task kick;
		@(posedge clk);
		pulse <= 1'b1;
		@(posedge clk);
		pulse <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	always @(posedge clk) begin
		if (rd_seen) begin
			t = q_exp.pop_front();
			chk(rdata & t[31:16], t[15:0]);
		end
		rd_seen <= bus.rd;
	end
	// ==========================================
	// scenarios
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rd(ADDR_CTRL, 16'h0, 16'h1f);
		rd(ADDR_SEQLEN, 16'h4, 16'hf);
		wr(4'hf, rnd());
		rd(4'hf, 16'h0, 16'hffff);
		tick(1);
		chk(16'(apwr), 16'h0);
		wr(ADDR_SEQLEN, 16'h0);
		wr(ADDR_CTRL, cw(1, 1, 0, 1, 0));
		wr(ADDR_START, rnd());
		tick(6);
		chk(16'(cclk), 16'h0);
		rd(ADDR_STATUS, 16'h0, 16'h3);
		$display("test end: start write refused");
		kick;
		wait_on(2, 6, n);
		chk(16'(n <= 3), 16'h1);
		tick(5);
		chk(16'({sclk, cclk, step}), 16'h3);
		chk(16'(apwr), 16'h1);
		kick;
		wait_on(1, 40, n);
		rd(ADDR_IRQ_STAT, 16'h3, 16'h3);
		wr(ADDR_IRQ_MASK, 16'h2);
		tick(1);
		chk(16'(irq), 16'h1);
		wr(ADDR_IRQ_STAT, 16'h3);
		tick(1);
		chk(16'(irq), 16'h0);
		rd(ADDR_IRQ_STAT, 16'h0, 16'h3);
		$display("test end: edge trigger and overrun");
		// polarity swapped with the trigger disabled so no spurious start
		wr(ADDR_CTRL, cw(1, 0, 1, 0, 0));
		@(posedge clk);
		pol <= 1'b0;
		tick(4);
		wr(ADDR_CTRL, cw(1, 1, 1, 0, 0));
		@(posedge clk);
		hold <= 1'b1;
		wait_on(0, 6, n);
		chk(16'(n <= 3), 16'h1);
		tick(6);
		@(posedge clk);
		hold <= 1'b0;
		tick(3);
		@(posedge clk);
		hold <= 1'b1;
		wait_on(1, 40, n);
		wait_on(2, 3, n);
		@(posedge clk);
		hold <= 1'b0;
		wait_on(1, 40, n);
		tick(6);
		chk(16'(cclk), 16'h0);
		rd(ADDR_IRQ_STAT, 16'h1, 16'h3);
		wr(ADDR_IRQ_STAT, 16'h3);
		$display("test end: level trigger");
		wr(ADDR_CTRL, cw(1, 0, 0, 1, 0));
		@(posedge clk);
		pol <= 1'b1;
		wr(ADDR_START, rnd());
		wait_on(0, 4, n);
		wr(ADDR_CTRL, cw(0, 0, 0, 1, 0));
		tick(1);
		chk(16'({sclk, cclk, apwr}), 16'h0);
		wr(ADDR_SEQLEN, 16'h3);
		rd(ADDR_SEQLEN, 16'h3, 16'hf);
		rd(ADDR_STATUS, 16'h0, 16'h3);
		wr(ADDR_CTRL, cw(1, 0, 0, 1, 0));
		tick(3);
		chk(16'(cclk), 16'h0);
		$display("test end: power-down abort");
		wr(ADDR_CTRL, cw(1, 0, 0, 1, 1));
		wr(ADDR_START, rnd());
		wait_on(0, 4, n);
		@(posedge clk);
		wt <= 1'b1;
		tick(4);
		chk(16'({sclk, cclk, step}), 16'h0);
		tick(60);
		@(posedge clk);
		wt <= 1'b0;
		wait_on(1, 80, n);
		chk(16'(n >= 40), 16'h1);
		wr(ADDR_CTRL, cw(1, 0, 0, 1, 0));
		wr(ADDR_START, rnd());
		wait_on(0, 4, n);
		@(posedge clk);
		wt <= 1'b1;
		wait_on(1, 70, n);
		@(posedge clk);
		wt <= 1'b0;
		$display("test end: wait halt");
		tick(3);
		report_and_stop;
	end
endmodule // test_adc_trigger_power_control
`default_nettype wire
